// [bench/dac_reference_control_test.sv]
// Self-checking bench for the ladder reference control block.
`define CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_total++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module dac_reference_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i, nrst_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i;
    logic [15:0] awaddr_i, araddr_i;
    logic [2:0] awprot_i, arprot_i;
    logic [31:0] wdata_i;
    logic [3:0] wstrb_i;
    logic [5:0] adc_channel_select_i;
    logic pin2_output_enable_i, pin1_port_oe_i, pin1_port_out_i, pin1_pullup_req_i, pin1_pad_i;
    logic pin2_port_oe_i, pin2_port_out_i, pin2_pullup_req_i, pin2_pad_i;
    logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, converter_enable_o, negative_source_o;
    logic [1:0] bresp_o, rresp_o;
    logic [31:0] rdata_o, tap_select_o;
    logic [4:0] level_code_o;
    logic [2:0] positive_source_o;
    logic comparator_ref_valid_o, adc_route_o;
    logic pin1_pad_o, pin1_pad_oe_o, pin1_pullup_en_o, pin1_input_detect_en_o, pin1_analog_connect_o, pin1_read_o;
    logic pin2_pad_o, pin2_pad_oe_o, pin2_pullup_en_o, pin2_input_detect_en_o, pin2_analog_connect_o, pin2_read_o;
    logic [31:0] rd;
    logic [1:0] resp;
    int err_total;
    int checks_done;
    localparam logic [15:0] CTRL_ADDR = 16'h3b18;
    localparam logic [15:0] LEVEL_ADDR = 16'h3b1c;
    localparam logic [15:0] HOLE_ADDR = 16'h3b20;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] lvl;
        logic [5:0] chan;
        logic p2;
        logic [2:0] pos;
    } row_s;

    // The disabled last row leaves the source outputs unchecked, though they still follow the control bits then.
    row_s rows [6] = '{
        '{8'h80, 8'h00, 6'h3e, 1'b0, 3'b001},
        '{8'h85, 8'h1f, 6'h3d, 1'b1, 3'b010},
        '{8'ha9, 8'h10, 6'h3e, 1'b0, 3'b100},
        '{8'h8c, 8'h0a, 6'h00, 1'b1, 3'b000},
        '{8'hff, 8'hff, 6'h3e, 1'b1, 3'b000},
        '{8'h2d, 8'h05, 6'h3e, 1'b0, 3'b000}
    };

    dac_reference_control DUT (
        .core_clk_i, .nrst_i, .awaddr_i, .awprot_i, .awvalid_i, .awready_o, .wdata_i, .wstrb_i,
        .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i, .araddr_i, .arprot_i, .arvalid_i,
        .arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i, .adc_channel_select_i,
        .pin2_output_enable_i, .pin1_port_oe_i, .pin1_port_out_i, .pin1_pullup_req_i, .pin1_pad_i,
        .pin2_port_oe_i, .pin2_port_out_i, .pin2_pullup_req_i, .pin2_pad_i, .converter_enable_o,
        .tap_select_o, .level_code_o, .positive_source_o, .negative_source_o, .comparator_ref_valid_o,
        .adc_route_o, .pin1_pad_o, .pin1_pad_oe_o, .pin1_pullup_en_o, .pin1_input_detect_en_o,
        .pin1_analog_connect_o, .pin1_read_o, .pin2_pad_o, .pin2_pad_oe_o, .pin2_pullup_en_o,
        .pin2_input_detect_en_o, .pin2_analog_connect_o, .pin2_read_o
    );

    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    task automatic axi_write(input logic [15:0] a, input logic [7:0] d, input logic [3:0] s, output logic [1:0] r);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge core_clk_i);
        awaddr_i <= a;
        wdata_i <= {24'h0, d};
        wstrb_i <= s;
        awvalid_i <= 1'b1;
        wvalid_i <= 1'b1;
        bready_i <= 1'b1;
        while (1) begin
            @(posedge core_clk_i);
            if (bvalid_o && aw_done && w_done) begin
                r = bresp_o;
                bready_i <= 1'b0;
                break;
            end
            if (awvalid_i && awready_o) begin
                awvalid_i <= 1'b0;
                aw_done = 1'b1;
            end
            if (wvalid_i && wready_o) begin
                wvalid_i <= 1'b0;
                w_done = 1'b1;
            end
        end
    endtask : axi_write

    task automatic axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk_i);
        araddr_i <= a;
        arvalid_i <= 1'b1;
        rready_i <= 1'b1;
        while (1) begin
            @(posedge core_clk_i);
            if (rvalid_o) begin
                d = rdata_o;
                r = rresp_o;
                rready_i <= 1'b0;
                break;
            end
            if (arvalid_i && arready_o) arvalid_i <= 1'b0;
        end
    endtask : axi_read

    task automatic do_reset();
        nrst_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        `CHECK({converter_enable_o, level_code_o, tap_select_o, pin1_analog_connect_o, bvalid_o, rvalid_o}, 41'h0)
        nrst_i <= 1'b1;
    endtask : do_reset

    initial begin
        repeat (20000) @(posedge core_clk_i);
        err_total++;
        results();
    end

    initial begin
        {awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = 5'h0;
        {awaddr_i, araddr_i, wdata_i, wstrb_i} = 68'h0;
        {awprot_i, arprot_i, adc_channel_select_i, pin2_output_enable_i} = 13'h0;
        // Port requests all high, so a pad that is not taken over shows every one of them.
        {pin1_port_oe_i, pin1_port_out_i, pin1_pullup_req_i, pin1_pad_i} = 4'hf;
        {pin2_port_oe_i, pin2_port_out_i, pin2_pullup_req_i, pin2_pad_i} = 4'hf;
        nrst_i = 1'b1;
        err_total = 0;
        checks_done = 0;
        do_reset();
        axi_read(CTRL_ADDR, rd, resp);
        `CHECK(rd, 32'h0)
        axi_read(LEVEL_ADDR, rd, resp);
        `CHECK(rd, 32'h0)
        $display("reset test done");
        for (int i = 0; i < 6; i++) begin
            adc_channel_select_i <= rows[i].chan;
            pin2_output_enable_i <= rows[i].p2;
            axi_write(CTRL_ADDR, rows[i].ctrl, 4'h1, resp);
            `CHECK(resp, 2'h0)
            axi_write(LEVEL_ADDR, rows[i].lvl, 4'h1, resp);
            axi_read(CTRL_ADDR, rd, resp);
            `CHECK(rd, {24'h0, rows[i].ctrl & 8'had})
            axi_read(LEVEL_ADDR, rd, resp);
            `CHECK({rd, resp}, {27'h0, rows[i].lvl[4:0], 2'h0})
            `CHECK(converter_enable_o, rows[i].ctrl[7])
            `CHECK(level_code_o, rows[i].lvl[4:0])
            `CHECK(tap_select_o, rows[i].ctrl[7] ? (32'h1 << rows[i].lvl[4:0]) : 32'h0)
            if (rows[i].ctrl[7]) begin
                `CHECK(positive_source_o, rows[i].pos)
                `CHECK(negative_source_o, rows[i].ctrl[0])
            end
            `CHECK(comparator_ref_valid_o, rows[i].ctrl[7])
            `CHECK(adc_route_o, rows[i].ctrl[7] && rows[i].chan == 6'h3e)
            `CHECK({pin1_pad_o, pin1_pad_oe_o, pin1_pullup_en_o, pin1_input_detect_en_o, pin1_analog_connect_o,
                    pin1_read_o}, rows[i].ctrl[5] ? 6'b000010 : 6'b111101)
            `CHECK({pin2_pad_o, pin2_pad_oe_o, pin2_pullup_en_o, pin2_input_detect_en_o, pin2_analog_connect_o,
                    pin2_read_o}, rows[i].p2 ? 6'b000010 : 6'b111101)
        end
        $display("table test done");
        axi_write(CTRL_ADDR, 8'h85, 4'h1, resp);
        axi_write(HOLE_ADDR, 8'hff, 4'h1, resp);
        `CHECK(resp, 2'h2)
        axi_read(HOLE_ADDR, rd, resp);
        `CHECK({rd, resp}, {32'h0, 2'h2})
        axi_write(CTRL_ADDR, 8'h00, 4'h0, resp);
        `CHECK(resp, 2'h0)
        // Nothing but reset or a write may touch the registers while the core idles.
        repeat (100) @(posedge core_clk_i);
        axi_read(CTRL_ADDR, rd, resp);
        `CHECK(rd, 32'h85)
        `CHECK(converter_enable_o, 1'b1)
        $display("unmapped and idle test done");
        axi_write(CTRL_ADDR, 8'hff, 4'h1, resp);
        axi_write(LEVEL_ADDR, 8'h1f, 4'h1, resp);
        @(posedge core_clk_i);
        do_reset();
        axi_read(CTRL_ADDR, rd, resp);
        `CHECK(rd, 32'h0)
        axi_read(LEVEL_ADDR, rd, resp);
        `CHECK(rd, 32'h0)
        `CHECK(pin1_pad_oe_o, 1'b1)
        $display("mid-run reset test done");
        results();
    end
endmodule : dac_reference_control_test

// [core/dac_axil_slave.sv]
// AXI4-Lite slave front end that turns bus transfers into register strobes.
module dac_axil_slave (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic [15:0] awaddr_i,
    input wire logic [2:0] awprot_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    input wire logic [15:0] araddr_i,
    input wire logic [2:0] arprot_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,
    output logic wr_pulse_o,
    output logic [13:0] wr_index_o,
    output logic [7:0] wr_data_o,
    output logic wr_lane0_o,
    output logic [13:0] rd_index_o,
    input wire logic [7:0] rd_data_i
);
    logic aw_full_reg;
    logic w_full_reg;
    logic [13:0] aw_index_reg;
    logic [7:0] w_data_reg;
    logic w_lane0_reg;

    // Protection bits carry no meaning here; every access is treated alike.
    assign awready_o = !aw_full_reg && !bvalid_o;
    assign wready_o = !w_full_reg && !bvalid_o;
    assign arready_o = !rvalid_o;
    assign wr_pulse_o = aw_full_reg && w_full_reg && !bvalid_o;
    assign wr_index_o = aw_index_reg;
    assign wr_data_o = w_data_reg;
    assign wr_lane0_o = w_lane0_reg;
    assign rd_index_o = dac_ref_pkg::reg_index(araddr_i);

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            aw_full_reg <= 1'b0;
            aw_index_reg <= 14'h0000;
        end else if (awvalid_i && awready_o) begin
            aw_full_reg <= 1'b1;
            aw_index_reg <= dac_ref_pkg::reg_index(awaddr_i);
        end else if (wr_pulse_o) begin
            aw_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            w_full_reg <= 1'b0;
            w_data_reg <= 8'h00;
            w_lane0_reg <= 1'b0;
        end else if (wvalid_i && wready_o) begin
            w_full_reg <= 1'b1;
            w_data_reg <= wdata_i[7:0];
            w_lane0_reg <= wstrb_i[0];
        end else if (wr_pulse_o) begin
            w_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bvalid_o <= 1'b0;
            bresp_o <= dac_ref_pkg::RESP_OKAY;
        end else if (wr_pulse_o) begin
            bvalid_o <= 1'b1;
            bresp_o <= dac_ref_pkg::is_mapped(aw_index_reg) ? dac_ref_pkg::RESP_OKAY : dac_ref_pkg::RESP_SLVERR;
        end else if (bready_i) begin
            bvalid_o <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rvalid_o <= 1'b0;
            rdata_o <= 32'h0000_0000;
            rresp_o <= dac_ref_pkg::RESP_OKAY;
        end else if (arvalid_i && arready_o) begin
            rvalid_o <= 1'b1;
            rdata_o <= {24'h00_0000, rd_data_i};
            rresp_o <= dac_ref_pkg::is_mapped(rd_index_o) ? dac_ref_pkg::RESP_OKAY : dac_ref_pkg::RESP_SLVERR;
        end else if (rready_i) begin
            rvalid_o <= 1'b0;
        end
    end
endmodule : dac_axil_slave

// [core/dac_pin_override.sv]
// Pad override for one reference output pin: takes the pad away from its digital functions.
module dac_pin_override (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire dac_ref_pkg::pin_ctrl_s ctrl_i,
    input wire logic pad_i,
    output logic pad_o,
    output logic pad_oe_o,
    output logic pullup_en_o,
    output logic input_detect_en_o,
    output logic analog_connect_o,
    output logic read_o
);
    logic pad_meta_reg;
    logic pad_sync_reg;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pad_meta_reg <= 1'b0;
            pad_sync_reg <= 1'b0;
        end else begin
            pad_meta_reg <= pad_i;
            pad_sync_reg <= pad_meta_reg;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pad_o <= 1'b0;
            pad_oe_o <= 1'b0;
            pullup_en_o <= 1'b0;
            input_detect_en_o <= 1'b0;
            analog_connect_o <= 1'b0;
            read_o <= 1'b0;
        end else begin
            pad_o <= ctrl_i.port_out && !ctrl_i.route;
            pad_oe_o <= ctrl_i.port_oe && !ctrl_i.route;
            pullup_en_o <= ctrl_i.pullup_req && !ctrl_i.route;
            input_detect_en_o <= !ctrl_i.route;
            analog_connect_o <= ctrl_i.route;
            // The analog level would read as noise, so the read is forced low.
            read_o <= pad_sync_reg && !ctrl_i.route;
        end
    end
endmodule : dac_pin_override

// [core/dac_ref_pkg.sv]
// Shared constants, types and decode helpers for the ladder reference control block.
package dac_ref_pkg;
    localparam int ADDR_W = 16;
    localparam int INDEX_W = 14;
    localparam logic [INDEX_W-1:0] CONTROL_INDEX = 14'h0ec6;
    localparam logic [INDEX_W-1:0] LEVEL_INDEX = 14'h0ec7;
    localparam int EN_BIT = 7;
    localparam int OE1_BIT = 5;
    localparam int PSS_LSB = 2;
    localparam int NSS_BIT = 0;
    localparam int LEVEL_W = 5;
    localparam int TAP_COUNT = 32;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] LEVEL_RESET = 8'h00;
    localparam logic [7:0] CONTROL_MASK = 8'had;
    localparam logic [7:0] LEVEL_MASK = 8'h1f;
    localparam logic [5:0] ADC_CONVERTER_CHANNEL = 6'h3e;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        POS_ANALOG_SUPPLY = 2'b00,
        POS_EXTERNAL_PIN = 2'b01,
        POS_FIXED_BUFFER = 2'b10,
        POS_RESERVED = 2'b11
    } positive_source_select_e;

    typedef struct packed {
        logic enable;
        logic pin1_output_enable;
        positive_source_select_e positive_source_select;
        logic negative_source_select;
    } control_s;

    typedef struct packed {
        logic route;
        logic port_oe;
        logic port_out;
        logic pullup_req;
    } pin_ctrl_s;

    function automatic logic [INDEX_W-1:0] reg_index(input logic [ADDR_W-1:0] addr);
        return addr[ADDR_W-1:2];
    endfunction : reg_index

    function automatic logic is_mapped(input logic [INDEX_W-1:0] idx);
        return (idx == CONTROL_INDEX) || (idx == LEVEL_INDEX);
    endfunction : is_mapped
endpackage : dac_ref_pkg

// [core/dac_reference_control.sv]
// Register file, ladder tap select and source steering for the 5-bit reference converter.
// What this block does
// - Five-bit level code picks one of 32 ladder taps.
// - Output is negative source plus difference times code over 32.
// - Control bit 7 turns the converter on and off.
// - Control bit 5 connects the level to the first output pin.
// - A routed pin loses its driver, pull-up and input detector.
// - Digital reads of a routed pin return zero.
// - Bits 3:2 pick supply, external pin or fixed buffer; 11 is reserved.
// - Control bit 0 picks external negative pin or analog ground.
// - Converter runs in sleep; wake leaves control contents untouched.
// - Reset disables converter, frees the first pin and clears every field; the second pin follows pin2_output_enable_i.
// - Control at index 0xEC6, level at 0xEC7, code in bits 4:0.
// - Level is offered to comparator, an ADC channel and two pins.
module dac_reference_control (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic [15:0] awaddr_i,
    input wire logic [2:0] awprot_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    input wire logic [15:0] araddr_i,
    input wire logic [2:0] arprot_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,
    input wire logic [5:0] adc_channel_select_i,
    input wire logic pin2_output_enable_i,
    input wire logic pin1_port_oe_i,
    input wire logic pin1_port_out_i,
    input wire logic pin1_pullup_req_i,
    input wire logic pin1_pad_i,
    input wire logic pin2_port_oe_i,
    input wire logic pin2_port_out_i,
    input wire logic pin2_pullup_req_i,
    input wire logic pin2_pad_i,
    output logic converter_enable_o,
    output logic [31:0] tap_select_o,
    output logic [4:0] level_code_o,
    output logic [2:0] positive_source_o,
    output logic negative_source_o,
    output logic comparator_ref_valid_o,
    output logic adc_route_o,
    output logic pin1_pad_o,
    output logic pin1_pad_oe_o,
    output logic pin1_pullup_en_o,
    output logic pin1_input_detect_en_o,
    output logic pin1_analog_connect_o,
    output logic pin1_read_o,
    output logic pin2_pad_o,
    output logic pin2_pad_oe_o,
    output logic pin2_pullup_en_o,
    output logic pin2_input_detect_en_o,
    output logic pin2_analog_connect_o,
    output logic pin2_read_o
);
    dac_ref_pkg::control_s control_reg;
    dac_ref_pkg::control_s control_next;
    logic [4:0] level_reg;
    logic [4:0] level_next;
    logic wr_pulse;
    logic [13:0] wr_index;
    logic [7:0] wr_data;
    logic wr_lane0;
    logic [13:0] rd_index;
    logic [7:0] rd_data;
    logic ctrl_write;
    logic level_write;
    dac_ref_pkg::pin_ctrl_s pin1_ctrl;
    dac_ref_pkg::pin_ctrl_s pin2_ctrl;

    dac_axil_slave u_bus (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .awaddr_i(awaddr_i),
        .awprot_i(awprot_i),
        .awvalid_i(awvalid_i),
        .awready_o(awready_o),
        .wdata_i(wdata_i),
        .wstrb_i(wstrb_i),
        .wvalid_i(wvalid_i),
        .wready_o(wready_o),
        .bresp_o(bresp_o),
        .bvalid_o(bvalid_o),
        .bready_i(bready_i),
        .araddr_i(araddr_i),
        .arprot_i(arprot_i),
        .arvalid_i(arvalid_i),
        .arready_o(arready_o),
        .rdata_o(rdata_o),
        .rresp_o(rresp_o),
        .rvalid_o(rvalid_o),
        .rready_i(rready_i),
        .wr_pulse_o(wr_pulse),
        .wr_index_o(wr_index),
        .wr_data_o(wr_data),
        .wr_lane0_o(wr_lane0),
        .rd_index_o(rd_index),
        .rd_data_i(rd_data)
    );

    assign ctrl_write = wr_pulse && wr_lane0 && (wr_index == dac_ref_pkg::CONTROL_INDEX);
    assign level_write = wr_pulse && wr_lane0 && (wr_index == dac_ref_pkg::LEVEL_INDEX);

    always_comb begin
        control_next = control_reg;
        if (ctrl_write) begin
            control_next.enable = wr_data[dac_ref_pkg::EN_BIT];
            control_next.pin1_output_enable = wr_data[dac_ref_pkg::OE1_BIT];
            control_next.positive_source_select =
                dac_ref_pkg::positive_source_select_e'(wr_data[dac_ref_pkg::PSS_LSB +: 2]);
            control_next.negative_source_select = wr_data[dac_ref_pkg::NSS_BIT];
        end
    end

    assign level_next = level_write ? wr_data[dac_ref_pkg::LEVEL_W-1:0] : level_reg;

    // Only a bus write or the device reset moves these; sleep and wake do not touch them.
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            control_reg <= dac_ref_pkg::control_s'(dac_ref_pkg::CONTROL_RESET[4:0]);
            level_reg <= dac_ref_pkg::LEVEL_RESET[dac_ref_pkg::LEVEL_W-1:0];
        end else begin
            control_reg <= control_next;
            level_reg <= level_next;
        end
    end

    always_comb begin
        rd_data = 8'h00;
        if (rd_index == dac_ref_pkg::CONTROL_INDEX) begin
            rd_data[dac_ref_pkg::EN_BIT] = control_reg.enable;
            rd_data[dac_ref_pkg::OE1_BIT] = control_reg.pin1_output_enable;
            rd_data[dac_ref_pkg::PSS_LSB +: 2] = control_reg.positive_source_select;
            rd_data[dac_ref_pkg::NSS_BIT] = control_reg.negative_source_select;
        end else if (rd_index == dac_ref_pkg::LEVEL_INDEX) begin
            rd_data[dac_ref_pkg::LEVEL_W-1:0] = level_reg;
        end
    end

    // The analog ladder divides between the two selected sources; this logic only closes one tap,
    // so the output tracks any drift of either source.
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            converter_enable_o <= 1'b0;
            tap_select_o <= 32'h0000_0000;
            level_code_o <= 5'h00;
            positive_source_o <= 3'h0;
            negative_source_o <= 1'b0;
        end else begin
            converter_enable_o <= control_next.enable;
            tap_select_o <= control_next.enable ? (32'h0000_0001 << level_next) : 32'h0000_0000;
            level_code_o <= level_next;
            negative_source_o <= control_next.negative_source_select;
            unique case (control_next.positive_source_select)
                dac_ref_pkg::POS_ANALOG_SUPPLY: positive_source_o <= 3'h1;
                dac_ref_pkg::POS_EXTERNAL_PIN: positive_source_o <= 3'h2;
                dac_ref_pkg::POS_FIXED_BUFFER: positive_source_o <= 3'h4;
                dac_ref_pkg::POS_RESERVED: positive_source_o <= 3'h0;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            comparator_ref_valid_o <= 1'b0;
            adc_route_o <= 1'b0;
        end else begin
            comparator_ref_valid_o <= control_next.enable;
            adc_route_o <= control_next.enable && (adc_channel_select_i == dac_ref_pkg::ADC_CONVERTER_CHANNEL);
        end
    end

    assign pin1_ctrl = '{route: control_reg.pin1_output_enable, port_oe: pin1_port_oe_i,
                         port_out: pin1_port_out_i, pullup_req: pin1_pullup_req_i};
    assign pin2_ctrl = '{route: pin2_output_enable_i, port_oe: pin2_port_oe_i,
                         port_out: pin2_port_out_i, pullup_req: pin2_pullup_req_i};

    dac_pin_override u_pin1 (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .ctrl_i(pin1_ctrl),
        .pad_i(pin1_pad_i),
        .pad_o(pin1_pad_o),
        .pad_oe_o(pin1_pad_oe_o),
        .pullup_en_o(pin1_pullup_en_o),
        .input_detect_en_o(pin1_input_detect_en_o),
        .analog_connect_o(pin1_analog_connect_o),
        .read_o(pin1_read_o)
    );

    dac_pin_override u_pin2 (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .ctrl_i(pin2_ctrl),
        .pad_i(pin2_pad_i),
        .pad_o(pin2_pad_o),
        .pad_oe_o(pin2_pad_oe_o),
        .pullup_en_o(pin2_pullup_en_o),
        .input_detect_en_o(pin2_input_detect_en_o),
        .analog_connect_o(pin2_analog_connect_o),
        .read_o(pin2_read_o)
    );

    logic first_cycle_reg;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            first_cycle_reg <= 1'b1;
        end else begin
            first_cycle_reg <= 1'b0;
        end
    end

    // Unimplemented bits differ between the two registers, so the read check must know which one answered.
    logic rd_level_reg;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_level_reg <= 1'b0;
        end else if (arvalid_i && arready_o) begin
            rd_level_reg <= (rd_index == dac_ref_pkg::LEVEL_INDEX);
        end
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!nrst_i);

    a_enable_write_on: assert property (ctrl_write && wr_data[7] |=> converter_enable_o)
        else $error("Enable write did not start the converter.");
    a_disabled_no_tap: assert property (!converter_enable_o |-> tap_select_o == 32'h0000_0000)
        else $error("A tap is closed while disabled.");
    a_tap_code_match: assert property (converter_enable_o |-> $onehot(tap_select_o) && tap_select_o[level_code_o])
        else $error("Closed tap does not match the level code.");
    a_level_write_tap: assert property (level_write && control_reg.enable && !ctrl_write
        |=> tap_select_o == (32'h0000_0001 << $past(wr_data[4:0])))
        else $error("Level write did not move the tap.");
    a_pos_reserved_off: assert property (control_reg.positive_source_select == 2'b11
        && $past(control_reg.positive_source_select) == 2'b11 |-> positive_source_o == 3'h0)
        else $error("Reserved positive code drives a source.");
    a_neg_write_sel: assert property (ctrl_write |=> negative_source_o == $past(wr_data[0]))
        else $error("Negative source did not follow bit 0.");
    a_pin_route_iso: assert property (control_reg.pin1_output_enable [*2] |->
        !pin1_pad_oe_o && !pin1_pullup_en_o && !pin1_input_detect_en_o && pin1_analog_connect_o)
        else $error("Routed pin keeps a digital function.");
    a_pin_read_zero: assert property (control_reg.pin1_output_enable [*2] |-> !pin1_read_o)
        else $error("Routed pin reads nonzero.");
    a_control_hold: assert property (!ctrl_write |=> $stable(control_reg))
        else $error("Control changed without a write.");
    a_reset_clears: assert property (first_cycle_reg |-> control_reg == 5'h00 && level_reg == 5'h00
        && !converter_enable_o && !pin1_analog_connect_o)
        else $error("Reset state is not all zero.");
    a_read_zero_upper: assert property (rvalid_o |-> rdata_o[31:8] == 24'h00_0000 && !rdata_o[6]
        && (rd_level_reg ? rdata_o[7:5] == 3'h0 : !rdata_o[4] && !rdata_o[1]))
        else $error("Unimplemented read bits are set.");
    a_adc_needs_en: assert property (adc_route_o |-> converter_enable_o && comparator_ref_valid_o)
        else $error("ADC route without an active converter.");

    // The pad stage adds one edge, so the pin checks wait until the route has stood for two cycles.
    a_pin2_route_iso: assert property (pin2_output_enable_i [*2] |-> !pin2_pad_oe_o
        && !pin2_pullup_en_o && !pin2_input_detect_en_o && !pin2_read_o && pin2_analog_connect_o)
        else $error("Routed second pin keeps a digital function.");
    a_pin_free_detect: assert property (!control_reg.pin1_output_enable [*2] |-> pin1_input_detect_en_o)
        else $error("Free pin lost its input detector.");
    a_pos_onehot_src: assert property ($onehot0(positive_source_o))
        else $error("Two positive sources are selected.");
    a_level_hold: assert property (!level_write |=> $stable(level_reg))
        else $error("Level changed without a write.");
    a_level_code_out: assert property (level_write |=> level_code_o == $past(wr_data[4:0]))
        else $error("Level code output missed a write.");

    a_write_resp: assert property (wr_pulse |=> bvalid_o)
        else $error("Register write gave no response.");
    a_unmapped_err: assert property (wr_pulse && wr_index != dac_ref_pkg::CONTROL_INDEX
        && wr_index != dac_ref_pkg::LEVEL_INDEX |=> bresp_o == dac_ref_pkg::RESP_SLVERR)
        else $error("Unmapped write was not refused.");
    a_bus_refused: assert property (bvalid_o |-> !awready_o && !wready_o)
        else $error("Write channels open while a response waits.");
    a_read_refused: assert property (rvalid_o |-> !arready_o)
        else $error("Read channel open while data waits.");
    a_read_resp: assert property (arvalid_i && arready_o |=> rvalid_o)
        else $error("Read request gave no response.");

    c_enable_write: cover property (ctrl_write ##1 converter_enable_o);
    c_pin_routed: cover property (control_reg.pin1_output_enable [*2] ##1 pin1_analog_connect_o);
    c_adc_ground: cover property (adc_route_o && level_code_o == 5'h00);
    c_reserved_pos: cover property (control_reg.positive_source_select == 2'b11);
    c_unmapped_write: cover property (wr_pulse ##1 bresp_o == dac_ref_pkg::RESP_SLVERR);
endmodule : dac_reference_control
